//--- hw/hsap_pkg.sv
package hsap_pkg;
   // Timing
   localparam int CLK_NS = 100;
   localparam int SYNC_CYCLES = 2;
   localparam int PRIV_TMO_NS = 2000;
   localparam int PRIV_TMO_CYC = (PRIV_TMO_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0] SYNC_LAST = 8'(SYNC_CYCLES - 1);
   localparam logic [7:0] TMO_LAST = 8'(PRIV_TMO_CYC - 1);

   // Register indexes and byte addresses
   localparam logic [7:0] IDX_IRQ = 8'h00;
   localparam logic [7:0] IDX_CTRL = 8'h02;
   localparam logic [7:0] IDX_ERR = 8'h03;
   localparam logic [7:0] ADDR_IRQ = 8'(IDX_IRQ * 4);
   localparam logic [7:0] ADDR_CTRL = 8'(IDX_CTRL * 4);
   localparam logic [7:0] ADDR_ERR = 8'(IDX_ERR * 4);

   // Control/status field positions
   localparam int CTRL_PER_PW = 0;
   localparam int CTRL_MODE_LO = 1;
   localparam int CTRL_MODE_HI = 2;
   localparam int CTRL_RAM_PW = 3;

   // Access mode field encodings
   localparam logic [1:0] MODE_SHARED = 2'h0;
   localparam logic [1:0] MODE_PER_HO = 2'h1;
   localparam logic [1:0] MODE_RAM_HO = 2'h2;
   localparam logic [1:0] MODE_HO = 2'h3;

   // Reset values
   localparam logic [1:0] MODE_RST = MODE_HO;
   localparam logic [7:0] IRQ_RST = 8'hFF;
   localparam logic PW_RST = 1'h0;

   // Error cause bits
   localparam int ERR_SEL = 0;
   localparam int ERR_REG = 1;
   localparam int ERR_TMO = 2;
   localparam int ERR_WID = 3;
   localparam int ERR_PRIV = 4;
   localparam int ERR_DSP = 5;

   // Host select encodings and exclusive block size (8K bytes)
   localparam logic [1:0] SEL_RAM = 2'h1;
   localparam logic [1:0] SEL_PER = 2'h2;
   localparam int EXCL_SHIFT = 13;

   typedef struct packed {
      logic we;
      logic [1:0] sel;
      logic size16;
      logic [23:0] addr;
      logic [15:0] wdata;
   } hsap_hreq_t;

   typedef struct packed {
      logic we;
      logic per;
      logic [23:0] addr;
      logic [15:0] wdata;
   } hsap_dreq_t;

   typedef struct packed {
      logic we;
      logic [23:0] addr;
      logic [15:0] wdata;
   } hsap_cmd_t;

   typedef enum logic [2:0] {H_IDLE, H_SYNC, H_ARB, H_BUSY, H_TMO} hsap_hstate_t;
   typedef enum logic [1:0] {D_IDLE, D_WAIT, D_BUSY} hsap_dstate_t;
endpackage : hsap_pkg

//--- hw/hsap_port.sv
// Contract
// R01 - Only DSP writes mode; host reads it
// R02 - RAM and peripherals moded independently
// R03 - Mode codes; mode 11 aborts DSP accesses
// R04 - DSP reset forces host-only on both
// R05 - DSP reset release selects shared on both
// R06 - Host-only RAM: DSP kept off exclusive part
// R07 - Host-only RAM: pass through, no waits
// R08 - Host-only peripherals: pass through, no resync
// R09 - Shared mode: resynchronise host accesses first
// R10 - Same memory block: DSP wins, host delayed
// R11 - Same peripheral together: DSP granted first
// R12 - Started host transfer finishes before DSP
// R13 - Host-only peripherals: DSP access bus error
// R14 - Host to private peripheral times out
// R15 - Posted writes acknowledged before completion
// R16 - Two posted enables, host only, reset 0
// R17 - Host-only change waits for posted writes
// R18 - Malformed host select aborts
// R19 - Wrong-direction register access aborts
// R20 - Bridge timeout relayed as host abort
// R21 - Width mismatch to peripheral aborts
// R22 - All bus errors recorded in cause register; DSP bridge timeout aborts are not recorded here
// R23 - DSP status interrupt forwarded to host
// R24 - Host zero write raises DSP interrupt
// R25 - Interrupt flags reset and return to ones
// R26 - Host-only resource ignores posted enable
//
// Decided for this implementation: the placing of the registers and strobed register access.
module hsap_port (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Host register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   output logic reg_abort,
   // Host transfer request and answer
   input wire logic host_req,
   input wire hsap_pkg::hsap_hreq_t host_in,
   output logic host_ready,
   output logic host_ack,
   output logic host_abort,
   output logic [15:0] host_rdata,
   // DSP side
   input wire logic dsp_reset,
   input wire logic dsp_mode_wr,
   input wire logic [1:0] dsp_mode_wdata,
   output logic [1:0] dsp_mode,
   input wire logic dsp_req,
   input wire hsap_pkg::hsap_dreq_t dsp_in,
   output logic dsp_ack,
   output logic dsp_abort,
   output logic [15:0] dsp_rdata,
   input wire logic [15:0] excl_size,
   // Interrupts
   input wire logic dsp_status_irq_n,
   output logic host_irq_n,
   output logic [7:0] dsp_irq,
   // Memory target
   output logic mem_req,
   output hsap_pkg::hsap_cmd_t mem_cmd,
   input wire logic mem_ack,
   input wire logic [15:0] mem_rdata,
   // Peripheral bus bridge target
   output logic per_req,
   output hsap_pkg::hsap_cmd_t per_cmd,
   input wire logic per_ack,
   input wire logic per_timeout,
   input wire logic [15:0] per_rdata,
   input wire logic per_is16,
   input wire logic per_private
);
   logic rst_q1;
   logic rst_n_s;
   logic dres_q1;
   logic dres_s;
   logic dres_d;
   logic irq_q1;
   logic [1:0] mode;
   logic [1:0] pend_mode;
   logic pend_valid;
   logic ram_pw_en;
   logic per_pw_en;
   logic [7:0] irq_flags;
   logic [7:0] err;
   logic [7:0] next_err;
   logic [7:0] err_ev;
   logic [7:0] cnt;
   logic hposted;
   hsap_pkg::hsap_hreq_t hreq;
   hsap_pkg::hsap_dreq_t dreq;
   hsap_pkg::hsap_hstate_t hstate;
   hsap_pkg::hsap_hstate_t next_hstate;
   hsap_pkg::hsap_dstate_t dstate;
   hsap_pkg::hsap_dstate_t next_dstate;

   // Reset release through two flip-flops
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_q1 <= 1'b0;
         rst_n_s <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_n_s <= rst_q1;
      end
   end

   // Synchronisers for DSP reset and the DSP status interrupt
   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         dres_q1 <= 1'b1;
         dres_s <= 1'b1;
         dres_d <= 1'b1;
         irq_q1 <= 1'b1;
         host_irq_n <= 1'b1;
      end else begin
         dres_q1 <= dsp_reset;
         dres_s <= dres_q1;
         dres_d <= dres_s;
         irq_q1 <= dsp_status_irq_n;
         host_irq_n <= irq_q1; // R23
      end
   end

   // Mode decode
   wire dres_fall = dres_d & ~dres_s;
   wire ram_ho = mode[1]; // R02
   wire per_ho = mode[0]; // R02
   wire to_ho = |(dsp_mode_wdata & ~mode);

   // Host request decode at take
   wire take = host_req & (hstate == hsap_pkg::H_IDLE);
   wire in_per = host_in.sel == hsap_pkg::SEL_PER;
   wire sel_bad = (host_in.sel != hsap_pkg::SEL_PER) && (host_in.sel != hsap_pkg::SEL_RAM);
   wire wmis = in_per & (host_in.size16 != per_is16); // R21
   wire h_bad = sel_bad | wmis; // R18
   wire h_priv = in_per & per_private;
   wire in_ho = in_per ? per_ho : ram_ho;
   wire in_pw = host_in.we & ~in_ho & (in_per ? per_pw_en : ram_pw_en); // R15 R26
   wire hq_per = hreq.sel == hsap_pkg::SEL_PER;

   // Resource claims between the two parties
   wire dsp_on_in = (dstate == hsap_pkg::D_BUSY) && (dreq.per == in_per);
   wire dsp_claims_q = (dstate != hsap_pkg::D_IDLE) && (dreq.per == hq_per); // R10 R11
   wire h_done_ev = hq_per ? (per_ack | per_timeout) : mem_ack;
   wire h_done = (hstate == hsap_pkg::H_BUSY) & h_done_ev;
   wire tmo_end = (hstate == hsap_pkg::H_TMO) && (cnt == hsap_pkg::TMO_LAST);

   // Host sequencer next state
   always_comb begin
      next_hstate = hstate;
      case (hstate)
         hsap_pkg::H_IDLE: begin
            if (take) begin
               if (h_bad) begin
                  next_hstate = hsap_pkg::H_IDLE;
               end else if (h_priv) begin
                  next_hstate = hsap_pkg::H_TMO; // R14
               end else if (in_ho && !dsp_on_in) begin
                  next_hstate = hsap_pkg::H_BUSY; // R07 R08
               end else if (in_ho) begin
                  next_hstate = hsap_pkg::H_ARB;
               end else begin
                  next_hstate = hsap_pkg::H_SYNC; // R09
               end
            end
         end
         hsap_pkg::H_SYNC: begin
            if (cnt == hsap_pkg::SYNC_LAST) begin
               next_hstate = hsap_pkg::H_ARB;
            end
         end
         hsap_pkg::H_ARB: begin
            if (!dsp_claims_q) begin
               next_hstate = hsap_pkg::H_BUSY; // R10 R11
            end
         end
         hsap_pkg::H_BUSY: begin
            if (h_done_ev) begin
               next_hstate = hsap_pkg::H_IDLE;
            end
         end
         hsap_pkg::H_TMO: begin
            if (tmo_end) begin
               next_hstate = hsap_pkg::H_IDLE;
            end
         end
         default: begin
            next_hstate = hsap_pkg::H_IDLE;
         end
      endcase
   end

   // Host issue source: live inputs on the direct path, held request otherwise
   wire host_go = (next_hstate == hsap_pkg::H_BUSY) && (hstate != hsap_pkg::H_BUSY);
   wire hsap_pkg::hsap_hreq_t hsrc = (hstate == hsap_pkg::H_IDLE) ? host_in : hreq;
   wire go_per = hsrc.sel == hsap_pkg::SEL_PER;
   wire h_holds_ram = ((hstate == hsap_pkg::H_BUSY) && !hq_per) || (host_go && !go_per);
   wire h_holds_per = ((hstate == hsap_pkg::H_BUSY) && hq_per) || (host_go && go_per);

   // DSP request decode
   wire d_take = dsp_req & (dstate == hsap_pkg::D_IDLE);
   wire [23:0] d_blk = dsp_in.addr >> hsap_pkg::EXCL_SHIFT;
   wire in_excl = d_blk < {8'h00, excl_size};
   wire d_bad_mode = mode == hsap_pkg::MODE_HO; // R03
   wire d_bad_per = dsp_in.per & per_ho; // R13
   wire d_bad_ram = ~dsp_in.per & ram_ho & in_excl; // R06
   wire d_bad = d_bad_mode | d_bad_per | d_bad_ram;
   wire d_holds = dreq.per ? h_holds_per : h_holds_ram;
   wire dsp_gnt = (dstate == hsap_pkg::D_WAIT) && !d_holds; // R12
   wire d_done = (dstate == hsap_pkg::D_BUSY) && (dreq.per ? (per_ack | per_timeout) : mem_ack);

   // DSP sequencer next state
   always_comb begin
      next_dstate = dstate;
      case (dstate)
         hsap_pkg::D_IDLE: begin
            if (d_take && !d_bad) begin
               next_dstate = hsap_pkg::D_WAIT;
            end
         end
         hsap_pkg::D_WAIT: begin
            if (dsp_gnt) begin
               next_dstate = hsap_pkg::D_BUSY;
            end
         end
         hsap_pkg::D_BUSY: begin
            if (d_done) begin
               next_dstate = hsap_pkg::D_IDLE;
            end
         end
         default: begin
            next_dstate = hsap_pkg::D_IDLE;
         end
      endcase
   end

   // Register decode
   wire wr_irq = reg_wr && (reg_addr == hsap_pkg::ADDR_IRQ);
   wire wr_ctrl = reg_wr && (reg_addr == hsap_pkg::ADDR_CTRL);
   wire wr_err = reg_wr && (reg_addr == hsap_pkg::ADDR_ERR);
   wire rd_irq = reg_rd && (reg_addr == hsap_pkg::ADDR_IRQ);
   wire rd_ctrl = reg_rd && (reg_addr == hsap_pkg::ADDR_CTRL);
   wire rd_err = reg_rd && (reg_addr == hsap_pkg::ADDR_ERR);
   wire reg_bad = rd_irq | wr_err; // R19
   wire [15:0] ctrl_val = {12'h000, ram_pw_en, mode, per_pw_en};

   // Error cause events; a new event beats a read clear
   wire per_tmo_hit = h_done && hq_per && per_timeout;
   assign err_ev = {2'h0, d_take & d_bad, tmo_end, take & wmis, per_tmo_hit, reg_bad,
                    take & sel_bad};
   assign next_err = (rd_err ? 8'h00 : err) | err_ev; // R22

   // Sequencer state, counter and held requests
   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         hstate <= hsap_pkg::H_IDLE;
         dstate <= hsap_pkg::D_IDLE;
         host_ready <= 1'b1;
         cnt <= 8'h00;
         hreq <= '0;
         dreq <= '0;
      end else begin
         hstate <= next_hstate;
         dstate <= next_dstate;
         host_ready <= next_hstate == hsap_pkg::H_IDLE;
         cnt <= (next_hstate != hstate) ? 8'h00 : cnt + 8'h01;
         if (take) begin
            hreq <= host_in;
         end
         if (d_take) begin
            dreq <= dsp_in;
         end
      end
   end

   // Posted write tracking
   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         hposted <= 1'b0;
      end else if (take && !h_bad) begin
         hposted <= in_pw; // R15
      end else if (h_done) begin
         hposted <= 1'b0;
      end
   end

   // Access mode field
   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         mode <= hsap_pkg::MODE_RST;
         pend_mode <= hsap_pkg::MODE_RST;
         pend_valid <= 1'b0;
      end else if (dres_s) begin
         mode <= hsap_pkg::MODE_HO; // R04
         pend_valid <= 1'b0;
      end else if (dres_fall) begin
         mode <= hsap_pkg::MODE_SHARED; // R05
      end else if (dsp_mode_wr && to_ho && hposted) begin
         pend_mode <= dsp_mode_wdata; // R17
         pend_valid <= 1'b1;
      end else if (dsp_mode_wr) begin
         mode <= dsp_mode_wdata; // R01
         pend_valid <= 1'b0;
      end else if (pend_valid && !hposted) begin
         mode <= pend_mode; // R17
         pend_valid <= 1'b0;
      end
   end

   // Host registers: posted enables, interrupt flags, error cause
   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         ram_pw_en <= hsap_pkg::PW_RST;
         per_pw_en <= hsap_pkg::PW_RST;
         irq_flags <= hsap_pkg::IRQ_RST;
         dsp_irq <= 8'h00;
         err <= 8'h00;
         dsp_mode <= hsap_pkg::MODE_RST;
      end else begin
         if (wr_ctrl) begin
            ram_pw_en <= reg_wdata[hsap_pkg::CTRL_RAM_PW]; // R16
            per_pw_en <= reg_wdata[hsap_pkg::CTRL_PER_PW]; // R16
         end
         irq_flags <= wr_irq ? reg_wdata[7:0] : hsap_pkg::IRQ_RST; // R25
         dsp_irq <= wr_irq ? ~reg_wdata[7:0] : 8'h00; // R24
         err <= next_err;
         dsp_mode <= next_hstate == hsap_pkg::H_IDLE ? mode : dsp_mode;
      end
   end

   // Register read data and abort, one cycle after the strobe
   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         reg_rdata <= 16'h0000;
         reg_abort <= 1'b0;
      end else begin
         reg_abort <= reg_bad; // R19
         reg_rdata <= rd_ctrl ? ctrl_val : (rd_err ? {8'h00, err} : 16'h0000);
      end
   end

   // Target ports: host and DSP never hold the same resource at once
   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         mem_req <= 1'b0;
         per_req <= 1'b0;
         mem_cmd <= '0;
         per_cmd <= '0;
      end else begin
         mem_req <= (host_go && !go_per) || (dsp_gnt && !dreq.per);
         per_req <= (host_go && go_per) || (dsp_gnt && dreq.per);
         if (host_go) begin
            if (go_per) begin
               per_cmd <= {hsrc.we, hsrc.addr, hsrc.wdata};
            end else begin
               mem_cmd <= {hsrc.we, hsrc.addr, hsrc.wdata};
            end
         end
         if (dsp_gnt) begin
            if (dreq.per) begin
               per_cmd <= {dreq.we, dreq.addr, dreq.wdata};
            end else begin
               mem_cmd <= {dreq.we, dreq.addr, dreq.wdata};
            end
         end
      end
   end

   // Host answers
   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         host_ack <= 1'b0;
         host_abort <= 1'b0;
         host_rdata <= 16'h0000;
      end else begin
         host_ack <= (take && !h_bad && !h_priv && in_pw) || (h_done && !hposted && !per_tmo_hit);
         host_abort <= (take && h_bad) || tmo_end || (per_tmo_hit && !hposted); // R18 R14 R20
         if (h_done && !hreq.we) begin
            host_rdata <= hq_per ? per_rdata : mem_rdata;
         end
      end
   end

   // DSP answers
   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         dsp_ack <= 1'b0;
         dsp_abort <= 1'b0;
         dsp_rdata <= 16'h0000;
      end else begin
         dsp_ack <= d_done && !(dreq.per && per_timeout);
         dsp_abort <= (d_take && d_bad) || (d_done && dreq.per && per_timeout); // R03 R13
         if (d_done && !dreq.we) begin
            dsp_rdata <= dreq.per ? per_rdata : mem_rdata;
         end
      end
   end

   // Checks
   localparam int TMO_MAX = 22;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n_s);

   sequence s_shared_take;
      take && !h_bad && !h_priv && !in_ho;
   endsequence

   AST_HOST_NO_MODE_WR: assert property (wr_ctrl && !dsp_mode_wr && !dres_s && !dres_fall // R01
      && !pend_valid |=> mode == $past(mode)) else $error("host write changed mode");
   AST_RESET_HO: assert property (dres_s |=> mode == hsap_pkg::MODE_HO) // R04
      else $error("mode not host-only in DSP reset");
   AST_RELEASE_SHARED: assert property (dres_fall |=> mode == hsap_pkg::MODE_SHARED) // R05
      else $error("mode not shared after DSP reset release");
   AST_DSP_PER_ERR: assert property (d_take && dsp_in.per && per_ho // R13
      |=> dsp_abort && dstate == hsap_pkg::D_IDLE) else $error("DSP peripheral access not refused");
   AST_MALFORMED: assert property (take && sel_bad |=> host_abort && !host_ack) // R18
      else $error("malformed host select not aborted");
   AST_IRQ_PULSE: assert property (wr_irq && !reg_wdata[0] // R24
      |=> dsp_irq[0] ##1 (irq_flags[0] || $past(wr_irq))) else $error("no DSP interrupt pulse");
   AST_SHARED_SYNC: assert property (s_shared_take |=> !host_go [*2]) // R09
      else $error("shared host access issued without resync");
   AST_DSP_WINS: assert property (hstate == hsap_pkg::H_ARB && dsp_claims_q |-> !host_go) // R10
      else $error("host granted over DSP");
   AST_POSTED_ACK: assert property (take && !h_bad && !h_priv && in_pw // R15
      |=> host_ack && hstate != hsap_pkg::H_IDLE) else $error("posted write not acked early");
   AST_PRIV_TMO: assert property (take && !h_bad && h_priv |=> ##[1:TMO_MAX] host_abort) // R14
      else $error("private peripheral access did not time out");
   AST_ERR_LOG: assert property (per_tmo_hit |=> err[hsap_pkg::ERR_TMO]) // R22
      else $error("bridge timeout not recorded");
endmodule : hsap_port

//--- tb/hsap_target_model.sv
module hsap_target_model (
   // Clock and pacing
   input wire logic clk,
   input wire logic slow,
   // Memory side
   input wire logic mem_req,
   input wire hsap_pkg::hsap_cmd_t mem_cmd,
   output logic mem_ack,
   output logic [15:0] mem_rdata,
   // Peripheral bridge side
   input wire logic per_req,
   input wire hsap_pkg::hsap_cmd_t per_cmd,
   output logic per_ack,
   output logic per_timeout,
   output logic [15:0] per_rdata,
   // Peripheral decode of the host address
   input wire logic [23:0] host_addr,
   output logic per_is16,
   output logic per_private
);
   timeunit 1ns;
   timeprecision 1ns;
   int mwait = 0;
   int pwait = 0;
   logic [23:0] maddr = 24'h0;
   logic [23:0] paddr = 24'h0;

   // Top address bits mark private and word-wide peripherals
   assign per_private = host_addr[23];
   assign per_is16 = host_addr[22];

   // Memory answers after a short or long stall; idle data inverted
   always @(posedge clk) begin
      mem_ack <= 1'h0;
      mem_rdata <= ~maddr[15:0];
      if (mem_req) begin
         mwait = slow ? 5 : 1;
         maddr = mem_cmd.addr;
      end else if (mwait > 0) begin
         mwait--;
         if (mwait == 0) begin
            mem_ack <= 1'h1;
            mem_rdata <= maddr[15:0] ^ 16'hA5C3;
         end
      end
   end

   // Bridge answers, or times out when address bit 21 is set
   always @(posedge clk) begin
      per_ack <= 1'h0;
      per_timeout <= 1'h0;
      per_rdata <= ~paddr[15:0];
      if (per_req) begin
         pwait = slow ? 5 : 1;
         paddr = per_cmd.addr;
      end else if (pwait > 0) begin
         pwait--;
         if (pwait == 0) begin
            per_timeout <= paddr[21];
            per_ack <= ~paddr[21];
            per_rdata <= paddr[15:0] ^ 16'hA5C3;
         end
      end
   end
endmodule : hsap_target_model

//--- tb/host_dsp_shared_access_port_tb.sv
module host_dsp_shared_access_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, reg_abort, host_req = 1'h0;
   logic [7:0] reg_addr = 8'h0, dsp_irq;
   logic [15:0] reg_wdata = 16'h0, reg_rdata, host_rdata, dsp_rdata, mem_rdata, per_rdata;
   hsap_pkg::hsap_hreq_t host_in = '0;
   hsap_pkg::hsap_dreq_t dsp_in = '0;
   hsap_pkg::hsap_cmd_t mem_cmd, per_cmd;
   logic host_ready, host_ack, host_abort, dsp_reset = 1'h1, dsp_mode_wr = 1'h0, dsp_req = 1'h0;
   logic [1:0] dsp_mode_wdata = 2'h0, dsp_mode;
   logic dsp_ack, dsp_abort, dsp_status_irq_n = 1'h1, host_irq_n, mem_req, mem_ack, per_req;
   logic per_ack, per_timeout, per_is16, per_private, slow = 1'h0, ab;
   logic [15:0] excl_size = 16'h1, d;
   logic [23:0] a, q[$];
   int error_cnt = 0, compares = 0, seed = 32'h1987e1c9, lat, rq, qs, i, n;

   always #50 clk = ~clk;

   // Command order at the targets
   always @(posedge clk) begin
      if (mem_req === 1'h1) q.push_back(mem_cmd.addr);
      if (per_req === 1'h1) q.push_back(per_cmd.addr);
   end

   hsap_port i_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_abort(reg_abort),
      .host_req(host_req), .host_in(host_in), .host_ready(host_ready), .host_ack(host_ack),
      .host_abort(host_abort), .host_rdata(host_rdata), .dsp_reset(dsp_reset),
      .dsp_mode_wr(dsp_mode_wr), .dsp_mode_wdata(dsp_mode_wdata), .dsp_mode(dsp_mode),
      .dsp_req(dsp_req), .dsp_in(dsp_in), .dsp_ack(dsp_ack), .dsp_abort(dsp_abort),
      .dsp_rdata(dsp_rdata), .excl_size(excl_size), .dsp_status_irq_n(dsp_status_irq_n),
      .host_irq_n(host_irq_n), .dsp_irq(dsp_irq), .mem_req(mem_req), .mem_cmd(mem_cmd),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata), .per_req(per_req), .per_cmd(per_cmd),
      .per_ack(per_ack), .per_timeout(per_timeout), .per_rdata(per_rdata),
      .per_is16(per_is16), .per_private(per_private));

   hsap_target_model i_tgt (.clk(clk), .slow(slow), .mem_req(mem_req), .mem_cmd(mem_cmd),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata), .per_req(per_req), .per_cmd(per_cmd),
      .per_ack(per_ack), .per_timeout(per_timeout), .per_rdata(per_rdata),
      .host_addr(host_in.addr), .per_is16(per_is16), .per_private(per_private));

   task automatic cmp_data(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_data

   task automatic cmp_cnt(input int got, input int exp);
      compares++;
      if (got != exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_cnt

   task automatic reg_write(input logic [7:0] ad, input logic [15:0] wd);
      @(posedge clk);
      reg_addr <= ad;
      reg_wdata <= wd;
      reg_wr <= 1'h1;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask : reg_write

   task automatic reg_read(input logic [7:0] ad);
      @(posedge clk);
      reg_addr <= ad;
      reg_rd <= 1'h1;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1;
      d = reg_rdata;
      ab = reg_abort;
   endtask : reg_read

   // One host transfer; lat and rq count cycles after the taking edge
   task automatic host_xfer(input logic we, input logic [1:0] sel, input logic s16,
                            input logic [23:0] ad);
      n = 0;
      while (host_ready !== 1'h1 && n < 200) begin
         @(posedge clk);
         #1;
         n++;
      end
      @(posedge clk);
      host_in <= {we, sel, s16, ad, 16'($random(seed))};
      host_req <= 1'h1;
      @(posedge clk);
      host_req <= 1'h0;
      lat = 0;
      rq = 0;
      while (lat < 200) begin
         #1;
         lat++;
         if (rq == 0 && (mem_req === 1'h1 || per_req === 1'h1)) rq = lat;
         if (host_ack === 1'h1 || host_abort === 1'h1) break;
         @(posedge clk);
      end
      ab = host_abort;
      d = host_rdata;
   endtask : host_xfer

   task automatic dsp_xfer(input logic per, input logic [23:0] ad);
      @(posedge clk);
      dsp_in <= {1'h0, per, ad, 16'h0};
      dsp_req <= 1'h1;
      @(posedge clk);
      dsp_req <= 1'h0;
      for (int k = 0; k < 200; k++) begin
         #1;
         if (dsp_ack === 1'h1 || dsp_abort === 1'h1) break;
         @(posedge clk);
      end
      ab = dsp_ack ? 1'h0 : (dsp_abort ? 1'h1 : 1'hx);
   endtask : dsp_xfer

   task automatic dsp_mode_set(input logic [1:0] m);
      @(posedge clk);
      dsp_mode_wr <= 1'h1;
      dsp_mode_wdata <= m;
      @(posedge clk);
      dsp_mode_wr <= 1'h0;
      repeat (3) @(posedge clk);
   endtask : dsp_mode_set

   task automatic end_sim;
      $display("compares=%0d error_cnt=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim

   // Watchdog
   initial begin
      #(100 * 20000);
      error_cnt++;
      end_sim();
   end

   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'h1;
      repeat (4) @(posedge clk);
      reg_read(hsap_pkg::ADDR_CTRL);
      cmp_data(d, 16'h0006);
      reg_write(hsap_pkg::ADDR_CTRL, 16'hFFFF);
      reg_read(hsap_pkg::ADDR_CTRL);
      cmp_data(d, 16'h000F);
      reg_write(hsap_pkg::ADDR_CTRL, 16'h0000);
      $display("test reset_ctrl done");
      for (i = 0; i < 8; i++) begin
         reg_write(hsap_pkg::ADDR_IRQ, 16'h00FF ^ (16'h1 << i));
         #1;
         cmp_data({8'h0, dsp_irq}, 16'h1 << i);
         @(posedge clk);
         #1;
         cmp_data({8'h0, dsp_irq}, 16'h0000);
      end
      reg_read(hsap_pkg::ADDR_IRQ);
      cmp_data({15'h0, ab}, 16'h1);
      reg_write(hsap_pkg::ADDR_ERR, 16'h0);
      #1;
      cmp_data({15'h0, reg_abort}, 16'h1);
      reg_read(hsap_pkg::ADDR_ERR);
      cmp_data(d, 16'h0002);
      reg_read(8'h40);
      cmp_data({d[14:0], ab}, 16'h0);
      $display("test registers done");
      a = {8'h0, 16'($random(seed))};
      host_xfer(1'h0, hsap_pkg::SEL_RAM, 1'h1, a);
      cmp_cnt(rq, 1);
      cmp_data(d, a[15:0] ^ 16'hA5C3);
      reg_write(hsap_pkg::ADDR_CTRL, 16'h0009);
      host_xfer(1'h1, hsap_pkg::SEL_RAM, 1'h1, a);
      cmp_cnt(int'(lat > rq && rq > 0), 1);
      host_xfer(1'h0, 2'h0, 1'h1, a);
      cmp_data({15'h0, ab}, 16'h1);
      host_xfer(1'h0, 2'h3, 1'h1, a);
      cmp_cnt(lat, 1);
      host_xfer(1'h0, hsap_pkg::SEL_PER, 1'h1, 24'h400010);
      cmp_cnt(rq, 1);
      cmp_data(d, 16'h0010 ^ 16'hA5C3);
      host_xfer(1'h0, hsap_pkg::SEL_PER, 1'h0, 24'h400020);
      cmp_cnt(lat, 1);
      host_xfer(1'h0, hsap_pkg::SEL_PER, 1'h1, 24'hC00000);
      cmp_cnt(lat, hsap_pkg::PRIV_TMO_CYC + 1);
      host_xfer(1'h0, hsap_pkg::SEL_PER, 1'h1, 24'h600000);
      cmp_data({15'h0, ab}, 16'h1);
      reg_read(hsap_pkg::ADDR_ERR);
      cmp_data(d, 16'h001D);
      $display("test host_only done");
      @(posedge clk);
      dsp_reset <= 1'h0;
      repeat (6) @(posedge clk);
      reg_read(hsap_pkg::ADDR_CTRL);
      cmp_data(d, 16'h0009);
      host_xfer(1'h0, hsap_pkg::SEL_RAM, 1'h1, a);
      cmp_cnt(int'(rq >= 3), 1);
      cmp_data(d, a[15:0] ^ 16'hA5C3);
      qs = q.size();
      slow <= 1'h1;
      host_xfer(1'h1, hsap_pkg::SEL_RAM, 1'h1, a);
      cmp_cnt(lat * 10 + rq, 10);
      dsp_mode_set(2'h3);
      reg_read(hsap_pkg::ADDR_CTRL);
      cmp_data(d, 16'h0009);
      for (n = 0; n < 100 && dsp_mode !== 2'h3; n++) @(posedge clk);
      cmp_cnt(q.size() - qs, 1);
      dsp_xfer(1'h0, 24'h004000);
      cmp_data({15'h0, ab}, 16'h1);
      dsp_mode_set(2'h1);
      dsp_xfer(1'h1, 24'h000040);
      cmp_data({15'h0, ab}, 16'h1);
      dsp_xfer(1'h0, 24'h004000);
      cmp_data({15'h0, ab}, 16'h0);
      dsp_mode_set(2'h2);
      dsp_xfer(1'h0, 24'h000100);
      cmp_data({15'h0, ab}, 16'h1);
      dsp_xfer(1'h0, 24'h004000);
      cmp_data({15'h0, ab}, 16'h0);
      dsp_mode_set(2'h0);
      $display("test modes done");
      for (i = 0; i < 2; i++) begin
         q.delete();
         fork
            host_xfer(1'h0, 2'(i + 1), 1'h1, 24'h400200);
            dsp_xfer(i[0], 24'h400300);
         join
         cmp_data(q[0][15:0], 16'h0300);
         q.delete();
         fork
            host_xfer(1'h0, 2'(i + 1), 1'h1, 24'h400200);
            begin
               repeat (7) @(posedge clk);
               dsp_xfer(i[0], 24'h400300);
            end
         join
         cmp_data(q[0][15:0], 16'h0200);
         cmp_data(d, 16'h0200 ^ 16'hA5C3);
      end
      $display("test conflicts done");
      @(posedge clk);
      dsp_status_irq_n <= 1'h0;
      repeat (3) @(posedge clk);
      #1;
      cmp_data({15'h0, host_irq_n}, 16'h0);
      $display("test dsp_irq done");
      end_sim();
   end
endmodule : host_dsp_shared_access_port_tb
